//--- common/gpc_pkg.sv
// package: register map, field layout and constants of the gpio config block
package gpc_pkg;

  localparam int GPC_NPINS = 21;
  localparam int GPC_P1_BASE = 8;
  localparam int GPC_P2_BASE = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GPC_ADDR_P0_FLAG = 8'h89;
  localparam logic [7:0] GPC_ADDR_P1_FLAG = 8'h8A;
  localparam logic [7:0] GPC_ADDR_P2_FLAG = 8'h8B;
  localparam logic [7:0] GPC_ADDR_P0_MODE = 8'h8F;
  localparam logic [7:0] GPC_ADDR_P1_MODE = 8'hF6;
  localparam logic [7:0] GPC_ADDR_P2_MODE = 8'hF7;
  localparam logic [7:0] GPC_ADDR_P0_DIR = 8'hFD;
  localparam logic [7:0] GPC_ADDR_P1_DIR = 8'hFE;
  localparam logic [7:0] GPC_ADDR_P2_DIR = 8'hFF;
  localparam logic [7:0] GPC_ADDR_EDGE_SEL = 8'h90;
  localparam logic [7:0] GPC_ADDR_IRQ_STAT = 8'h91;
  localparam logic [7:0] GPC_ADDR_IRQ_MASK = 8'h92;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GPC_PRIO_LSB = 6;
  localparam int GPC_P2_UNUSED_BIT = 5;
  localparam int GPC_P1_MODE_LSB = 2;
  localparam int GPC_PORT2_PULL_POLARITY_BIT = 7;
  localparam int GPC_PORT1_PULL_POLARITY_BIT = 6;
  localparam int GPC_PORT0_PULL_POLARITY_BIT = 5;
  localparam int GPC_USB_RESUME_BIT = 7;
  localparam int GPC_IRQ_P0 = 0;
  localparam int GPC_IRQ_P1 = 1;
  localparam int GPC_IRQ_P2 = 2;
  localparam int GPC_IRQ_USB = 3;

  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] GPC_RST_BYTE = 8'h00;
  localparam logic [7:0] GPC_P0_FLAG_MASK_USB = 8'hBF;
  localparam logic [7:0] GPC_P0_FLAG_MASK_STD = 8'hFF;
  localparam logic [2:0] GPC_SYNC_FILL = 3'h4;

  // ----------------------------------------------------------------
  // peripherals that compete for shared port 0 pins
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GPC_SER0 = 4'h1,
    GPC_SER1 = 4'h2,
    GPC_TMR1_CH01 = 4'h4,
    GPC_TMR1_CH2 = 4'h8
  } gpc_periph_e;

endpackage

//--- common/gpc_pin_if.sv
// interface: pad levels in, synchronised levels and edge pulses out
`timescale 1ns/1ns
`default_nettype none
interface gpc_pin_if;
  import gpc_pkg::*;
  logic [GPC_NPINS-1:0] pad_in;
  logic [GPC_NPINS-1:0] level;
  logic [GPC_NPINS-1:0] rise;
  logic [GPC_NPINS-1:0] fall;
  modport sync (input pad_in, output level, rise, fall);
  modport core (output pad_in, input level, rise, fall);
endinterface
`default_nettype wire

//--- hdl/gpc_edge_sync.sv
// three-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
`default_nettype none
module gpc_edge_sync
  import gpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  gpc_pin_if.sync pins
);

  typedef struct packed {
    logic [GPC_NPINS-1:0] s1;
    logic [GPC_NPINS-1:0] s2;
    logic [GPC_NPINS-1:0] s3;
    logic [GPC_NPINS-1:0] level;
    logic [GPC_NPINS-1:0] rise;
    logic [GPC_NPINS-1:0] fall;
    logic [2:0] fill;
  } gpc_sync_s;

  gpc_sync_s r;
  gpc_sync_s next_r;
  logic [GPC_NPINS-1:0] agree;

  // ----------------------------------------------------------------
  // a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.s1 = pins.pad_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    agree = ~(r.s2 ^ r.s3);
    next_r.level = (agree & r.s3) | (~agree & r.level);
    next_r.rise = '0;
    next_r.fall = '0;
    if (r.fill == GPC_SYNC_FILL) begin
      next_r.rise = agree & r.s3 & ~r.level;
      next_r.fall = agree & ~r.s3 & r.level;
    end else begin
      next_r.fill = r.fill + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pins.level = r.level;
  assign pins.rise = r.rise;
  assign pins.fall = r.fall;

endmodule
`default_nettype wire

//--- hdl/gpc_top.sv
// gpio port direction, input mode, priority and pending flag registers
//
// Operation
// - port 0 pins drive when direction bit is 1, input when 0; reset input
// - port 1 pins drive when direction bit is 1, input when 0; reset input
// - port 2 direction in bits 4:0, 1 output, resets to inputs
// - bits 7:6 of port 2 direction choose winner on shared port 0 pins
// - port 2 direction bit 5 unused, reads zero, resets zero
// - port 0 mode bit 0 pulls the input, 1 leaves it tristate
// - port 1 mode bits only for pins 7..2; bits 1:0 read zero
// - port 2 mode bits 4:0 choose pulled or tristate, reset zero
// - port 2 input register bit 7 picks pull-up or pull-down for port 2
// - bit 6 picks pull polarity for port 1, pins 1 and 0 excluded
// - bit 5 picks pull polarity for pulled port 0 pins
// - standard variant: eight port 0 pending flags, cleared by writing 0
// - usb variant: bit 7 resume flag, bit 6 unused, bits 5:0 pin flags
// - eight port 1 pending flags, cleared only by writing 0
// - port 2 pending flags in bits 4:0; bits 7:5 read zero
// - flag rises on rising edge if port select is 0, falling if 1
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module gpc_top
  import gpc_pkg::*;
#(
  parameter bit USB_VARIANT = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] p0_pad_in,
  output logic [7:0] p0_pad_out,
  output logic [7:0] p0_pad_oe_n,
  input wire logic [7:0] p0_dout,
  output logic [7:0] p0_pull_en,
  output logic [7:0] p0_pull_dn,
  output logic [7:0] p0_level,
  input wire logic [7:0] p1_pad_in,
  output logic [7:0] p1_pad_out,
  output logic [7:0] p1_pad_oe_n,
  input wire logic [7:0] p1_dout,
  output logic [7:0] p1_pull_en,
  output logic [7:0] p1_pull_dn,
  output logic [7:0] p1_level,
  input wire logic [4:0] p2_pad_in,
  output logic [4:0] p2_pad_out,
  output logic [4:0] p2_pad_oe_n,
  input wire logic [4:0] p2_dout,
  output logic [4:0] p2_pull_en,
  output logic [4:0] p2_pull_dn,
  output logic [4:0] p2_level,
  input wire logic usb_resume_evt,
  output gpc_periph_e prio_winner,
  output gpc_periph_e prio_loser,
  output logic irq
);

  typedef struct packed {
    logic [7:0] p0_dir;
    logic [7:0] p1_dir;
    logic [4:0] p2_dir;
    logic [1:0] prio;
    logic [7:0] p0_mode;
    logic [5:0] p1_mode;
    logic [4:0] p2_mode;
    logic port0_pull_polarity;
    logic port1_pull_polarity;
    logic port2_pull_polarity;
    logic [7:0] p0_flag;
    logic [7:0] p1_flag;
    logic [4:0] p2_flag;
    logic [2:0] edge_sel;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [7:0] rdata;
    logic [GPC_NPINS-1:0] pad_q;
  } gpc_regs_s;

  gpc_regs_s r;
  gpc_regs_s next_r;
  gpc_pin_if pins ();

  logic [7:0] p0_set;
  logic [7:0] p1_set;
  logic [4:0] p2_set;
  logic [7:0] p0_pick;
  logic [7:0] p2_pick;
  logic [7:0] p2_flag_w;
  logic [7:0] p0_valid;
  logic [3:0] irq_evt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] edge_pick(
    input logic [7:0] rise,
    input logic [7:0] fall,
    input logic fall_sel
  );
    edge_pick = fall_sel ? fall : rise;
  endfunction

  // flag update: write 0 clears, write 1 keeps, a set wins
  function automatic logic [7:0] w0c(
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic we,
    input logic [7:0] set
  );
    w0c = (we ? (cur & wdata) : cur) | set;
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  assign pins.pad_in = {p2_pad_in, p1_pad_in, p0_pad_in};

  gpc_edge_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pins(pins)
  );

  // ----------------------------------------------------------------
  // edge events into flags
  // ----------------------------------------------------------------
  assign p0_pick = edge_pick(pins.rise[7:0], pins.fall[7:0],
                             r.edge_sel[0]);
  assign p1_set = edge_pick(pins.rise[GPC_P1_BASE +: 8],
                            pins.fall[GPC_P1_BASE +: 8],
                            r.edge_sel[1]);
  assign p2_pick = edge_pick({3'h0, pins.rise[GPC_P2_BASE +: 5]},
                             {3'h0, pins.fall[GPC_P2_BASE +: 5]},
                             r.edge_sel[2]);
  assign p2_set = p2_pick[4:0];
  assign p0_set = USB_VARIANT ? {usb_resume_evt, 1'b0, p0_pick[5:0]}
                              : p0_pick;
  assign p0_valid = USB_VARIANT ? GPC_P0_FLAG_MASK_USB
                                : GPC_P0_FLAG_MASK_STD;

  assign irq_evt[GPC_IRQ_P0] = |(USB_VARIANT ? {2'h0, p0_set[5:0]}
                                             : p0_set);
  assign irq_evt[GPC_IRQ_P1] = |p1_set;
  assign irq_evt[GPC_IRQ_P2] = |p2_set;
  assign irq_evt[GPC_IRQ_USB] = USB_VARIANT & usb_resume_evt;

  // ----------------------------------------------------------------
  // register writes, reads and flag updates
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.pad_q = {p2_dout, p1_dout, p0_dout};
    next_r.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        GPC_ADDR_P0_DIR: begin
          next_r.p0_dir = reg_wdata;
        end
        GPC_ADDR_P1_DIR: begin
          next_r.p1_dir = reg_wdata;
        end
        GPC_ADDR_P2_DIR: begin
          next_r.p2_dir = reg_wdata[4:0];
          next_r.prio = reg_wdata[GPC_PRIO_LSB +: 2];
        end
        GPC_ADDR_P0_MODE: begin
          next_r.p0_mode = reg_wdata;
        end
        GPC_ADDR_P1_MODE: begin
          next_r.p1_mode = reg_wdata[7:GPC_P1_MODE_LSB];
        end
        GPC_ADDR_P2_MODE: begin
          next_r.p2_mode = reg_wdata[4:0];
          next_r.port2_pull_polarity = reg_wdata[GPC_PORT2_PULL_POLARITY_BIT];
          next_r.port1_pull_polarity = reg_wdata[GPC_PORT1_PULL_POLARITY_BIT];
          next_r.port0_pull_polarity = reg_wdata[GPC_PORT0_PULL_POLARITY_BIT];
        end
        GPC_ADDR_EDGE_SEL: begin
          next_r.edge_sel = reg_wdata[2:0];
        end
        GPC_ADDR_IRQ_MASK: begin
          next_r.irq_mask = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    next_r.p0_flag = w0c(r.p0_flag, reg_wdata,
                         reg_wr && reg_addr == GPC_ADDR_P0_FLAG,
                         p0_set) & p0_valid;
    next_r.p1_flag = w0c(r.p1_flag, reg_wdata,
                         reg_wr && reg_addr == GPC_ADDR_P1_FLAG,
                         p1_set);
    p2_flag_w = w0c({3'h0, r.p2_flag}, reg_wdata,
                    reg_wr && reg_addr == GPC_ADDR_P2_FLAG,
                    {3'h0, p2_set});
    next_r.p2_flag = p2_flag_w[4:0];
    // status: write 1 clears, new event wins
    next_r.irq_stat = ((reg_wr && reg_addr == GPC_ADDR_IRQ_STAT) ?
                       (r.irq_stat & ~reg_wdata[3:0]) : r.irq_stat)
                      | irq_evt;
    if (reg_rd) begin
      case (reg_addr)
        GPC_ADDR_P0_DIR: next_r.rdata = r.p0_dir;
        GPC_ADDR_P1_DIR: next_r.rdata = r.p1_dir;
        GPC_ADDR_P2_DIR: next_r.rdata = {r.prio, 1'b0, r.p2_dir};
        GPC_ADDR_P0_MODE: next_r.rdata = r.p0_mode;
        GPC_ADDR_P1_MODE: next_r.rdata = {r.p1_mode, 2'h0};
        GPC_ADDR_P2_MODE: begin
          next_r.rdata = {r.port2_pull_polarity, r.port1_pull_polarity, r.port0_pull_polarity, r.p2_mode};
        end
        GPC_ADDR_P0_FLAG: next_r.rdata = r.p0_flag;
        GPC_ADDR_P1_FLAG: next_r.rdata = r.p1_flag;
        GPC_ADDR_P2_FLAG: next_r.rdata = {3'h0, r.p2_flag};
        GPC_ADDR_EDGE_SEL: next_r.rdata = {5'h00, r.edge_sel};
        GPC_ADDR_IRQ_STAT: next_r.rdata = {4'h0, r.irq_stat};
        GPC_ADDR_IRQ_MASK: next_r.rdata = {4'h0, r.irq_mask};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // pad drive and pull control
  // ----------------------------------------------------------------
  assign p0_pad_out = r.pad_q[7:0];
  assign p1_pad_out = r.pad_q[GPC_P1_BASE +: 8];
  assign p2_pad_out = r.pad_q[GPC_P2_BASE +: 5];
  assign p0_pad_oe_n = ~r.p0_dir;
  assign p1_pad_oe_n = ~r.p1_dir;
  assign p2_pad_oe_n = ~r.p2_dir;
  assign p0_pull_en = ~r.p0_dir & ~r.p0_mode;
  assign p1_pull_en = {~r.p1_dir[7:2] & ~r.p1_mode, 2'h0};
  assign p2_pull_en = ~r.p2_dir & ~r.p2_mode;
  assign p0_pull_dn = p0_pull_en & {8{r.port0_pull_polarity}};
  assign p1_pull_dn = p1_pull_en & {8{r.port1_pull_polarity}};
  assign p2_pull_dn = p2_pull_en & {5{r.port2_pull_polarity}};
  assign p0_level = pins.level[7:0];
  assign p1_level = pins.level[GPC_P1_BASE +: 8];
  assign p2_level = pins.level[GPC_P2_BASE +: 5];
  assign reg_rdata = r.rdata;
  assign irq = |(r.irq_stat & r.irq_mask);

  // ----------------------------------------------------------------
  // shared pin priority
  // ----------------------------------------------------------------
  always_comb begin
    case (r.prio)
      2'b00: begin
        prio_winner = GPC_SER0;
        prio_loser = GPC_SER1;
      end
      2'b01: begin
        prio_winner = GPC_SER1;
        prio_loser = GPC_SER0;
      end
      2'b10: begin
        prio_winner = GPC_TMR1_CH01;
        prio_loser = GPC_SER1;
      end
      default: begin
        prio_winner = GPC_TMR1_CH2;
        prio_loser = GPC_SER0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_p0_dir_drive: assert property (
    reg_wr && reg_addr == GPC_ADDR_P0_DIR
    |=> p0_pad_oe_n == ~$past(reg_wdata))
    else $error("port 0 direction not applied");

  a_p1_dir_drive: assert property (
    reg_wr && reg_addr == GPC_ADDR_P1_DIR
    |=> p1_pad_oe_n == ~$past(reg_wdata))
    else $error("port 1 direction not applied");

  a_p2_dir_drive: assert property (
    reg_wr && reg_addr == GPC_ADDR_P2_DIR
    |=> p2_pad_oe_n == ~$past(reg_wdata[4:0]))
    else $error("port 2 direction not applied");

  a_prio_decode: assert property (
    reg_wr && reg_addr == GPC_ADDR_P2_DIR && reg_wdata[7:6] == 2'b11
    |=> prio_winner == GPC_TMR1_CH2 && prio_loser == GPC_SER0)
    else $error("priority decode wrong");

  a_p2_dir_unused: assert property (
    reg_rd && reg_addr == GPC_ADDR_P2_DIR |=> reg_rdata[5] == 1'b0)
    else $error("port 2 direction bit 5 not zero");

  a_p0_mode_tri: assert property (
    reg_wr && reg_addr == GPC_ADDR_P0_MODE && reg_wdata == 8'hFF
    |=> p0_pull_en == 8'h00)
    else $error("tristate port 0 still pulled");

  a_p1_low_nopull: assert property (
    p1_pull_en[1:0] == 2'h0 && p1_pull_dn[1:0] == 2'h0)
    else $error("port 1 pins 1:0 pulled");

  a_p2_pull_dn: assert property (
    reg_wr && reg_addr == GPC_ADDR_P2_MODE && reg_wdata == 8'h80
    |=> p2_pull_dn == ~r.p2_dir)
    else $error("port 2 pull-down not applied");

  a_p1_edge_set: assert property (
    pins.rise[GPC_P1_BASE] && !r.edge_sel[1] |=> r.p1_flag[0])
    else $error("rising edge did not raise flag");

  a_p1_flag_w0c: assert property (
    reg_wr && reg_addr == GPC_ADDR_P1_FLAG
    |=> r.p1_flag == (($past(r.p1_flag) & $past(reg_wdata))
                      | $past(p1_set)))
    else $error("port 1 flag write wrong");

  a_p2_flag_hi: assert property (
    reg_rd && reg_addr == GPC_ADDR_P2_FLAG |=> reg_rdata[7:5] == 3'h0)
    else $error("port 2 flag upper bits not zero");

  a_usb_resume: assert property (
    USB_VARIANT && usb_resume_evt
    |=> r.p0_flag[GPC_USB_RESUME_BIT] && !r.p0_flag[6])
    else $error("resume flag not set");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

endmodule
`default_nettype wire

//--- tb/gpc_board.sv
// board model: pads driven by the block, an outside source, pulls or noise
`timescale 1ns/1ns
`default_nettype none
module gpc_board #(
  parameter int W = 8
)
(
  input wire logic clk_sys,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] pull_dn,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad
);
  logic [W-1:0] noise = '0;
  // floating pad never holds a value
  always @(posedge clk_sys) begin
    noise <= ~noise;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i]) begin
        pad[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pull_en[i]) begin
        pad[i] = ~pull_dn[i];
      end else begin
        pad[i] = noise[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/gpio_port_config_and_flags_tb.sv
// self-checking bench for the gpio config and flag registers
`timescale 1ns/1ns
`default_nettype none
module gpio_port_config_and_flags_tb;
  import gpc_pkg::*;
  logic clk_sys, rstn, reg_wr, reg_rd, irq, usb_resume_evt;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, e0, e1, e2, fa, fb;
  logic [7:0] p0_pad_in, p0_pad_out, p0_pad_oe_n, p0_dout, p0_pull_en;
  logic [7:0] p0_pull_dn, p0_level, ext0;
  logic [7:0] p1_pad_in, p1_pad_out, p1_pad_oe_n, p1_dout, p1_pull_en;
  logic [7:0] p1_pull_dn, p1_level, ext1;
  logic [4:0] p2_pad_in, p2_pad_out, p2_pad_oe_n, p2_dout, p2_pull_en;
  logic [4:0] p2_pull_dn, p2_level, ext2, en2;
  logic [7:0] en0, en1, ru, rdata_u;
  gpc_periph_e prio_winner, prio_loser;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  logic [31:0] seed = 32'h520A;
  logic [7:0] regs [6];
  localparam logic [7:0] RA [6] = '{GPC_ADDR_P0_DIR, GPC_ADDR_P1_DIR,
    GPC_ADDR_P2_DIR, GPC_ADDR_P0_MODE, GPC_ADDR_P1_MODE, GPC_ADDR_P2_MODE};
  localparam logic [7:0] RM [6] = '{8'hFF, 8'hFF, 8'hDF, 8'hFF, 8'hFC, 8'hFF};

  gpc_top #(.USB_VARIANT(1'b0)) DUT (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p0_pad_in(p0_pad_in),
    .p0_pad_out(p0_pad_out), .p0_pad_oe_n(p0_pad_oe_n), .p0_dout(p0_dout),
    .p0_pull_en(p0_pull_en), .p0_pull_dn(p0_pull_dn), .p0_level(p0_level),
    .p1_pad_in(p1_pad_in), .p1_pad_out(p1_pad_out),
    .p1_pad_oe_n(p1_pad_oe_n), .p1_dout(p1_dout), .p1_pull_en(p1_pull_en),
    .p1_pull_dn(p1_pull_dn), .p1_level(p1_level), .p2_pad_in(p2_pad_in),
    .p2_pad_out(p2_pad_out), .p2_pad_oe_n(p2_pad_oe_n), .p2_dout(p2_dout),
    .p2_pull_en(p2_pull_en), .p2_pull_dn(p2_pull_dn), .p2_level(p2_level),
    .usb_resume_evt(usb_resume_evt), .prio_winner(prio_winner),
    .prio_loser(prio_loser), .irq(irq));
  gpc_top #(.USB_VARIANT(1'b1)) DUT_USB (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata_u), .p0_pad_in(p0_pad_in),
    .p0_pad_out(), .p0_pad_oe_n(), .p0_dout(p0_dout), .p0_pull_en(),
    .p0_pull_dn(), .p0_level(), .p1_pad_in(p1_pad_in), .p1_pad_out(),
    .p1_pad_oe_n(), .p1_dout(p1_dout), .p1_pull_en(), .p1_pull_dn(),
    .p1_level(), .p2_pad_in(p2_pad_in), .p2_pad_out(), .p2_pad_oe_n(),
    .p2_dout(p2_dout), .p2_pull_en(), .p2_pull_dn(), .p2_level(),
    .usb_resume_evt(usb_resume_evt), .prio_winner(), .prio_loser(),
    .irq());
  gpc_board board0 (.clk_sys(clk_sys), .pad_out(p0_pad_out),
    .oe_n(p0_pad_oe_n), .pull_en(p0_pull_en), .pull_dn(p0_pull_dn),
    .ext_en(en0), .ext_val(ext0), .pad(p0_pad_in));
  gpc_board board1 (.clk_sys(clk_sys), .pad_out(p1_pad_out),
    .oe_n(p1_pad_oe_n), .pull_en(p1_pull_en), .pull_dn(p1_pull_dn),
    .ext_en(en1), .ext_val(ext1), .pad(p1_pad_in));
  gpc_board #(.W(5)) board2 (.clk_sys(clk_sys), .pad_out(p2_pad_out),
    .oe_n(p2_pad_oe_n), .pull_en(p2_pull_en), .pull_dn(p2_pull_dn),
    .ext_en(en2), .ext_val(ext2), .pad(p2_pad_in));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] prio_exp(input logic [1:0] c);
    case (c)
      2'h0: return {GPC_SER0, GPC_SER1};
      2'h1: return {GPC_SER1, GPC_SER0};
      2'h2: return {GPC_TMR1_CH01, GPC_SER1};
      default: return {GPC_TMR1_CH2, GPC_SER0};
    endcase
  endfunction
  // expected pad level: driven pins show data, free pulled pins the pull
  function automatic logic [7:0] lvl(input logic [7:0] dir, dat, en, pul,
                                     input logic dn);
    return (dir & dat) | (pul & ~en & {8{~dn}});
  endfunction

  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp, what);
    ru = rdata_u;
    @(negedge clk_sys);
    chk(reg_rdata, 8'h00, "read data held");
    @(posedge clk_sys);
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge clk_sys);
    chk({7'h0, irq}, {7'h0, exp}, "irq level");
    @(posedge clk_sys);
  endtask
  task automatic pin(input int p, input int i, input logic v);
    case (p)
      0: ext0[i] <= v;
      1: ext1[i] <= v;
      default: ext2[i] <= v;
    endcase
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, usb_resume_evt, reg_addr, reg_wdata} = '0;
    {p0_dout, p1_dout, p2_dout, ext0, ext1, ext2} = '0;
    {en0, en1, en2} = '1;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    // ----------------------------------------------------------------
    // reset values, then priority decode for all four codes
    // ----------------------------------------------------------------
    for (int i = 0; i < 6; i++) rdc(RA[i], 8'h00, "reset");
    for (int i = 0; i < 3; i++) rdc(8'h89 + i, 8'h00, "flag reset");
    chk(p0_pad_oe_n & p1_pad_oe_n, 8'hFF, "oe reset");
    chk({3'h0, p2_pad_oe_n}, 8'h1F, "p2 oe reset");
    chk({prio_winner, prio_loser}, prio_exp(2'h0), "prio reset");
    for (int c = 0; c < 4; c++) begin
      wr(GPC_ADDR_P2_DIR, 8'(c << 6));
      chk({prio_winner, prio_loser}, prio_exp(2'(c)), "prio");
    end
    // ----------------------------------------------------------------
    // random configuration and pin controls
    // ----------------------------------------------------------------
    repeat (6) begin
      p0_dout <= rnd();
      p1_dout <= rnd();
      p2_dout <= 5'(rnd());
      en0 <= rnd();
      en1 <= rnd();
      en2 <= 5'(rnd());
      for (int i = 0; i < 6; i++) regs[i] = rnd();
      for (int i = 0; i < 6; i++) wr(RA[i], regs[i]);
      for (int i = 0; i < 6; i++) rdc(RA[i], regs[i] & RM[i], "rw");
      e0 = ~regs[0] & ~regs[3];
      e1 = ~regs[1] & ~regs[4] & 8'hFC;
      e2 = ~regs[2] & ~regs[5] & 8'h1F;
      chk(p0_pad_oe_n, ~regs[0], "p0 oe");
      chk(p1_pad_oe_n, ~regs[1], "p1 oe");
      chk({3'h0, p2_pad_oe_n}, ~regs[2] & 8'h1F, "p2 oe");
      chk({prio_winner, prio_loser}, prio_exp(regs[2][7:6]), "prio");
      chk(p0_pull_en, e0, "p0 pull");
      chk(p1_pull_en, e1, "p1 pull");
      chk({3'h0, p2_pull_en}, e2, "p2 pull");
      chk(p2_pull_dn & e2[4:0], {5{regs[5][7]}} & e2, "p2 dn");
      chk(p1_pull_dn & e1, {8{regs[5][6]}} & e1, "p1 dn");
      chk(p0_pull_dn & e0, {8{regs[5][5]}} & e0, "p0 dn");
      chk(p0_pad_out ^ p0_dout, 8'h00, "p0 drive");
      chk(p1_pad_out, p1_dout, "p1 drive");
      chk({3'h0, p2_pad_out}, {3'h0, p2_dout}, "p2 drive");
      chk(p0_level & (regs[0] | en0 | e0),
          lvl(regs[0], p0_dout, en0, e0, regs[5][5]), "p0 level");
      chk(p1_level & (regs[1] | en1 | e1),
          lvl(regs[1], p1_dout, en1, e1, regs[5][6]), "p1 level");
      chk({3'h0, p2_level} & (regs[2] | {3'h0, en2} | e2),
          lvl(regs[2], {3'h0, p2_dout}, {3'h0, en2}, e2, regs[5][7]),
          "p2 level");
    end
    wr(GPC_ADDR_P2_MODE, 8'h80);
    chk({3'h0, p2_pull_dn}, ~regs[2] & 8'h1F, "p2 pull-down");
    wr(GPC_ADDR_P0_MODE, 8'hFF);
    chk(p0_pull_en, 8'h00, "p0 tristate");
    wr(8'h00, 8'hA5);
    rdc(8'h00, 8'h00, "unmapped");
    en0 <= 8'hFF;
    en1 <= 8'hFF;
    en2 <= 5'h1F;
    // ----------------------------------------------------------------
    // pending flags, edge select, interrupt
    // ----------------------------------------------------------------
    for (int i = 0; i < 6; i++) wr(RA[i], 8'h00);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) wr(8'h89 + i, 8'h00);
    wr(GPC_ADDR_IRQ_STAT, 8'hFF);
    wr(GPC_ADDR_EDGE_SEL, 8'h00);
    for (int p = 0; p < 3; p++) begin
      n = rnd() % (p == 2 ? 5 : 8);
      fa = GPC_ADDR_P0_FLAG + 8'(p);
      fb = 8'h01 << n;
      pin(p, n, 1'b1);
      rdc(fa, fb, "rise flag");
      chk(ru, p == 0 ? fb & 8'h3F : fb, "usb pin flag");
      rdc(GPC_ADDR_IRQ_STAT, 8'h01 << p, "irq status");
      chk_irq(1'b0);
      wr(GPC_ADDR_IRQ_MASK, 8'h01 << p);
      chk_irq(1'b1);
      wr(fa, 8'hFF);
      rdc(fa, fb, "write one keeps");
      wr(fa, ~fb);
      rdc(fa, 8'h00, "cleared");
      pin(p, n, 1'b0);
      rdc(fa, 8'h00, "fall ignored");
      wr(GPC_ADDR_EDGE_SEL, 8'h01 << p);
      pin(p, n, 1'b1);
      rdc(fa, 8'h00, "rise ignored");
      pin(p, n, 1'b0);
      rdc(fa, fb, "fall flag");
      wr(fa, 8'h00);
      wr(GPC_ADDR_IRQ_STAT, 8'hFF);
      wr(GPC_ADDR_EDGE_SEL, 8'h00);
      chk_irq(1'b0);
      wr(GPC_ADDR_IRQ_MASK, 8'h00);
    end
    // ----------------------------------------------------------------
    // resume flag on the usb variant, then reset in mid-run
    // ----------------------------------------------------------------
    usb_resume_evt <= 1'b1;
    @(posedge clk_sys);
    usb_resume_evt <= 1'b0;
    rdc(GPC_ADDR_P0_FLAG, 8'h00, "no resume flag");
    chk(ru, 8'h80, "resume flag");
    wr(GPC_ADDR_P0_FLAG, 8'h7F);
    rdc(GPC_ADDR_P0_FLAG, 8'h00, "flags clear");
    chk(ru, 8'h00, "resume cleared");
    for (int i = 0; i < 6; i++) wr(RA[i], 8'hFF);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) rdc(RA[i], 8'h00, "mid reset");
    chk(p0_pad_oe_n & p1_pad_oe_n, 8'hFF, "oe mid reset");
    end_of_test();
  end
endmodule
`default_nettype wire
